// *** hdl/motor_cfg_regs.sv ***
// register bank holding the closed-loop stop, motor and gain configuration
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "motor_cfg_consts.svh"

// What this block does
// - stop field selects hi-z, brake, spin-down or align
// - brake duration code maps to milliseconds
// - spin-down threshold code maps to percent of max
// - brake threshold uses the same percent table
// - resistance code lives in bits 15 to 8
// - inductance code lives in bits 7 to 0
// - back-emf code lives in bits 30 to 23
// - current kp is mantissa over ten-power exponent
// - current ki is thousand times mantissa over exponent
// - zero current gains request automatic gain calculation
// - low three bits hold speed kp top bits
// - speed kp low seven bits join the top
// - maximum speed is a 14-bit hertz value
module motor_cfg_regs
    import motor_cfg_pkg::*;
#(
    parameter int SPEED_W = 14,
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave port
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // decoded configuration towards the motor control core
    output motor_cfg_t cfg_o,
    output logic [SPEED_W-1:0] spin_down_speed_o,
    output logic [SPEED_W-1:0] brake_speed_o
);

    // ****************************************************************
    // address decode
    // ****************************************************************

    // word address compare; byte lanes below the word are ignored
    function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        if (addr[ADDR_W-1:12] != '0) begin
            decode_addr = SEL_NONE;
        end else begin
            case (addr[11:2])
                `STOP_BRAKE_RL_IDX: decode_addr = SEL_STOP;
                `BEMF_GAINS_IDX: decode_addr = SEL_GAIN;
                `SPEED_CFG_IDX: decode_addr = SEL_SPEED;
                `CFG_STATUS_IDX: decode_addr = SEL_STATUS;
                default: decode_addr = SEL_NONE;
            endcase
        end
    endfunction

    // ****************************************************************
    // storage
    // ****************************************************************

    // stored words
    logic [31:0] stop_brake_and_motor_rl; // stop, brake and motor r/l codes
    logic [31:0] bemf_and_loop_gains; // back-emf code and loop gains
    logic [31:0] speed_cfg; // speed kp low bits and maximum speed

    // bus pipeline
    logic wr_pending; // a write data phase is due this cycle
    reg_sel_t wr_sel; // register targeted by the pending write
    reg_sel_t addr_sel; // register named in the current address phase
    logic addr_valid; // an address phase is accepted this cycle

    // read side
    logic [31:0] status_word; // read-only view of decoded state
    logic [31:0] next_rdata; // read data for the coming data phase
    logic [31:0] fwd_stop; // stop word as seen after a pending write
    logic [31:0] fwd_gain; // gain word as seen after a pending write
    logic [31:0] fwd_speed; // speed word as seen after a pending write

    // decode helpers
    logic [9:0] next_spd_kp; // joined speed-loop kp code
    logic next_curr_auto; // both current gain codes are zero
    stop_action_t next_action; // stop action from the stop field

    // ****************************************************************
    // ahb-lite address phase
    // ****************************************************************

    // nonseq or seq with the bus ready; idle and busy are ignored
    always_comb begin
        addr_valid = hsel_i && htrans_i[1] && hready_i;
        addr_sel = decode_addr(haddr_i);
    end

    // remember a write so its data can be taken one cycle later
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pending <= 1'b0;
            wr_sel <= SEL_NONE;
        end else begin
            wr_pending <= addr_valid && hwrite_i;
            wr_sel <= addr_sel;
        end
    end

    // zero wait states and always okay, so both stay constant after reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // ****************************************************************
    // register writes in the data phase
    // ****************************************************************

    // whole word is stored, reserved codes included, so reads return them
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_brake_and_motor_rl <= `CFG_RESET_VALUE;
        end else if (wr_pending && wr_sel == SEL_STOP) begin
            stop_brake_and_motor_rl <= hwdata_i;
        end
    end

    // gain word; writing zero gains is how software asks for auto gains
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bemf_and_loop_gains <= `CFG_RESET_VALUE;
        end else if (wr_pending && wr_sel == SEL_GAIN) begin
            bemf_and_loop_gains <= hwdata_i;
        end
    end

    // speed word carrying the rest of speed kp and the maximum speed
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_cfg <= `CFG_RESET_VALUE;
        end else if (wr_pending && wr_sel == SEL_SPEED) begin
            speed_cfg <= hwdata_i;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************

    // forward pending write data so a read right behind a write is fresh
    always_comb begin
        fwd_stop = stop_brake_and_motor_rl;
        fwd_gain = bemf_and_loop_gains;
        fwd_speed = speed_cfg;
        if (wr_pending) begin
            case (wr_sel)
                SEL_STOP: fwd_stop = hwdata_i;
                SEL_GAIN: fwd_gain = hwdata_i;
                SEL_SPEED: fwd_speed = hwdata_i;
                default: fwd_stop = stop_brake_and_motor_rl;
            endcase
        end
    end

    // status shows the decoded state held in the output flops
    always_comb begin
        status_word = '0;
        status_word[`STAT_AUTO_BIT] = cfg_o.curr_auto;
        status_word[`STAT_RSVD_BIT] = (cfg_o.action == STOP_RESERVED);
        status_word[`STAT_BRAKE_MS_HI:`STAT_BRAKE_MS_LO] = cfg_o.brake_ms;
    end

    // unmapped addresses read as zero and writes to them are dropped
    always_comb begin
        case (addr_sel)
            SEL_STOP: next_rdata = fwd_stop;
            SEL_GAIN: next_rdata = fwd_gain;
            SEL_SPEED: next_rdata = fwd_speed;
            SEL_STATUS: next_rdata = status_word;
            default: next_rdata = '0;
        endcase
    end

    // read data is captured at the address phase and held until the next read
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= '0;
        end else if (addr_valid && !hwrite_i) begin
            hrdata_o <= next_rdata;
        end
    end

    // ****************************************************************
    // field decoding
    // ****************************************************************

    // brake duration table; short codes all collapse to 1 ms
    function automatic logic [13:0] brake_time_ms(input logic [3:0] code);
        case (code)
            4'h5: brake_time_ms = 14'h0005;
            4'h6: brake_time_ms = 14'h000A;
            4'h7: brake_time_ms = 14'h0032;
            4'h8: brake_time_ms = 14'h0064;
            4'h9: brake_time_ms = 14'h00FA;
            4'hA: brake_time_ms = 14'h01F4;
            4'hB: brake_time_ms = 14'h03E8;
            4'hC: brake_time_ms = 14'h09C4;
            4'hD: brake_time_ms = 14'h1388;
            4'hE: brake_time_ms = 14'h2710;
            4'hF: brake_time_ms = 14'h3A98;
            default: brake_time_ms = 14'h0001;
        endcase
    endfunction

    // stop field to one-hot action; unused codes flag reserved
    always_comb begin
        case (stop_brake_and_motor_rl[`STOP_SEL_HI:`STOP_SEL_LO])
            3'h0: next_action = STOP_HIZ;
            3'h2: next_action = STOP_LOW_BRAKE;
            3'h3: next_action = STOP_HIGH_BRAKE;
            3'h4: next_action = STOP_SPIN_DOWN;
            3'h5: next_action = STOP_ALIGN_BRAKE;
            default: next_action = STOP_RESERVED;
        endcase
    end

    // auto gains only when both current gain codes are zero
    always_comb begin
        next_curr_auto = (bemf_and_loop_gains[`CURR_KP_HI:`CURR_KP_LO] == '0) &&
                         (bemf_and_loop_gains[`CURR_KI_HI:`CURR_KI_LO] == '0);
    end

    // the speed kp code straddles two words
    always_comb begin
        next_spd_kp = {bemf_and_loop_gains[`SPD_KP_TOP_HI:`SPD_KP_TOP_LO],
                       speed_cfg[`SPD_KP_LOW_HI:`SPD_KP_LOW_LO]};
    end

    // ****************************************************************
    // decoded outputs
    // ****************************************************************

    // stop behaviour towards the stop sequencer
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.action <= STOP_HIZ;
        end else begin
            cfg_o.action <= next_action;
        end
    end

    // brake time; reset shows the shortest, 1 ms
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.brake_ms <= 14'h0001;
        end else begin
            cfg_o.brake_ms <= brake_time_ms(stop_brake_and_motor_rl[`BRAKE_DUR_HI:`BRAKE_DUR_LO]);
        end
    end

    // motor model codes; the lookup into ohms and henries is downstream
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.res_code <= '0;
            cfg_o.ind_code <= '0;
        end else begin
            cfg_o.res_code <= stop_brake_and_motor_rl[`RES_CODE_HI:`RES_CODE_LO];
            cfg_o.ind_code <= stop_brake_and_motor_rl[`IND_CODE_HI:`IND_CODE_LO];
        end
    end

    // back-emf code comes from the gain word
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.bemf_code <= '0;
        end else begin
            cfg_o.bemf_code <= bemf_and_loop_gains[`BEMF_CODE_HI:`BEMF_CODE_LO];
        end
    end

    // gain codes split into mantissa and exponent; the core applies the scale
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.curr_kp <= '0;
            cfg_o.curr_ki <= '0;
            cfg_o.spd_kp <= '0;
        end else begin
            cfg_o.curr_kp <= bemf_and_loop_gains[`CURR_KP_HI:`CURR_KP_LO];
            cfg_o.curr_ki <= bemf_and_loop_gains[`CURR_KI_HI:`CURR_KI_LO];
            cfg_o.spd_kp <= next_spd_kp;
        end
    end

    // auto flag; zeroed gains at reset already ask for it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.curr_auto <= 1'b1;
        end else begin
            cfg_o.curr_auto <= next_curr_auto;
        end
    end

    // maximum speed that every percentage threshold scales against
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.max_speed <= '0;
        end else begin
            cfg_o.max_speed <= speed_cfg[`MAX_SPEED_HI:`MAX_SPEED_LO];
        end
    end

    // ****************************************************************
    // speed thresholds
    // ****************************************************************

    // two instances share one table; the converter registers its result
    speed_threshold #(
        .SPEED_W(SPEED_W)
    ) u_spin_thr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .code_i(stop_brake_and_motor_rl[`SPIN_THR_HI:`SPIN_THR_LO]),
        .max_speed_i(speed_cfg[SPEED_W-1:0]),
        .speed_o(spin_down_speed_o)
    );

    // brake pin and brake stop options share this threshold
    speed_threshold #(
        .SPEED_W(SPEED_W)
    ) u_brake_thr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .code_i(stop_brake_and_motor_rl[`BRAKE_THR_HI:`BRAKE_THR_LO]),
        .max_speed_i(speed_cfg[SPEED_W-1:0]),
        .speed_o(brake_speed_o)
    );

endmodule // motor_cfg_regs

// *** hdl/motor_cfg_consts.svh ***
// offsets, field positions and reset values of the motor configuration registers
`ifndef MOTOR_CFG_CONSTS_SVH
`define MOTOR_CFG_CONSTS_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define STOP_BRAKE_RL_IDX 10'h08A
`define BEMF_GAINS_IDX 10'h08C
`define SPEED_CFG_IDX 10'h08E
`define CFG_STATUS_IDX 10'h090
`define STOP_BRAKE_RL_ADDR 32'h00000228
`define BEMF_GAINS_ADDR 32'h00000230
`define SPEED_CFG_ADDR 32'h00000238
`define CFG_STATUS_ADDR 32'h00000240

// ****************************************************************
// field positions of stop_brake_and_motor_rl
// ****************************************************************
`define STOP_SEL_HI 30
`define STOP_SEL_LO 28
`define BRAKE_DUR_HI 27
`define BRAKE_DUR_LO 24
`define SPIN_THR_HI 23
`define SPIN_THR_LO 20
`define BRAKE_THR_HI 19
`define BRAKE_THR_LO 16
`define RES_CODE_HI 15
`define RES_CODE_LO 8
`define IND_CODE_HI 7
`define IND_CODE_LO 0

// ****************************************************************
// field positions of bemf_and_loop_gains
// ****************************************************************
`define BEMF_CODE_HI 30
`define BEMF_CODE_LO 23
`define CURR_KP_HI 22
`define CURR_KP_LO 13
`define CURR_KI_HI 12
`define CURR_KI_LO 3
`define SPD_KP_TOP_HI 2
`define SPD_KP_TOP_LO 0

// ****************************************************************
// field positions of the speed configuration word
// ****************************************************************
`define SPD_KP_LOW_HI 30
`define SPD_KP_LOW_LO 24
`define MAX_SPEED_HI 13
`define MAX_SPEED_LO 0

// ****************************************************************
// status word layout and reset values
// ****************************************************************
`define STAT_AUTO_BIT 31
`define STAT_RSVD_BIT 30
`define STAT_BRAKE_MS_HI 13
`define STAT_BRAKE_MS_LO 0
`define CFG_RESET_VALUE 32'h00000000
`define PERMILLE_FULL 24'h0003E8

`endif

// *** hdl/motor_cfg_pkg.sv ***
// types shared by the motor configuration register bank
package motor_cfg_pkg;

    // one-hot stop action decoded from the stop-behaviour field
    typedef enum logic [5:0] {
        STOP_HIZ = 6'h01,
        STOP_LOW_BRAKE = 6'h02,
        STOP_HIGH_BRAKE = 6'h04,
        STOP_SPIN_DOWN = 6'h08,
        STOP_ALIGN_BRAKE = 6'h10,
        STOP_RESERVED = 6'h20
    } stop_action_t;

    // one-hot register select from the address decoder
    typedef enum logic [4:0] {
        SEL_NONE = 5'h01,
        SEL_STOP = 5'h02,
        SEL_GAIN = 5'h04,
        SEL_SPEED = 5'h08,
        SEL_STATUS = 5'h10
    } reg_sel_t;

    // gain code: value = mantissa / 10^exponent times a per-loop scale
    typedef struct packed {
        logic [1:0] exponent;
        logic [7:0] mantissa;
    } gain_code_t;

    // decoded configuration handed to the motor control core
    typedef struct packed {
        stop_action_t action;
        logic [13:0] brake_ms;
        logic [7:0] res_code;
        logic [7:0] ind_code;
        logic [7:0] bemf_code;
        gain_code_t curr_kp;
        gain_code_t curr_ki;
        gain_code_t spd_kp;
        logic curr_auto;
        logic [13:0] max_speed;
    } motor_cfg_t;

endpackage

// *** hdl/speed_threshold.sv ***
// converts a 4-bit percentage threshold code into a speed in electrical hertz
`timescale 1ns/1ps
`include "motor_cfg_consts.svh"

module speed_threshold
    import motor_cfg_pkg::*;
#(
    parameter int SPEED_W = 14
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] code_i,
    input wire logic [SPEED_W-1:0] max_speed_i,
    output logic [SPEED_W-1:0] speed_o
);

    // ****************************************************************
    // percentage table in tenths of a percent
    // ****************************************************************
    function automatic logic [9:0] permille(input logic [3:0] code);
        case (code)
            4'h0: permille = 10'h3E8; // 100 %
            4'h1: permille = 10'h384; // 90 %
            4'h2: permille = 10'h320; // 80 %
            4'h3: permille = 10'h2BC; // 70 %
            4'h4: permille = 10'h258; // 60 %
            4'h5: permille = 10'h1F4; // 50 %
            4'h6: permille = 10'h1C2; // 45 %
            4'h7: permille = 10'h190; // 40 %
            4'h8: permille = 10'h15E; // 35 %
            4'h9: permille = 10'h12C; // 30 %
            4'hA: permille = 10'h0FA; // 25 %
            4'hB: permille = 10'h0C8; // 20 %
            4'hC: permille = 10'h096; // 15 %
            4'hD: permille = 10'h064; // 10 %
            4'hE: permille = 10'h032; // 5 %
            default: permille = 10'h019; // 2.5 %
        endcase
    endfunction

    logic [SPEED_W+9:0] product; // max speed times tenths of a percent
    logic [SPEED_W+9:0] quotient; // scaled back to hertz, truncated

    // the divide is by a constant, so it folds into a multiplier network
    always_comb begin
        product = (SPEED_W+10)'(max_speed_i) * (SPEED_W+10)'(permille(code_i));
        quotient = product / (SPEED_W+10)'(`PERMILLE_FULL);
    end

    // registered so the divider path never reaches the core directly
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_o <= '0;
        end else begin
            speed_o <= quotient[SPEED_W-1:0];
        end
    end

endmodule // speed_threshold

// *** bench/motor_cfg_checker.sv ***
// concurrent checks on the ports of the motor configuration register bank
`timescale 1ns/1ps
`include "motor_cfg_consts.svh"

module motor_cfg_checker
    import motor_cfg_pkg::*;
#(
    parameter int SPEED_W = 14,
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire motor_cfg_t cfg_o,
    input wire logic [SPEED_W-1:0] spin_down_speed_o,
    input wire logic [SPEED_W-1:0] brake_speed_o
);
    // ****************************************************************
    // expected decodes
    // ****************************************************************
    localparam logic [31:0] A_STOP = `STOP_BRAKE_RL_ADDR; // stop and motor word
    localparam logic [31:0] A_GAIN = `BEMF_GAINS_ADDR; // back-emf and gains word
    localparam logic [31:0] A_SPD = `SPEED_CFG_ADDR; // speed kp low and max speed
    // brake time in ms per duration code
    localparam logic [13:0] MS_TAB [16] = '{14'h0001, 14'h0001, 14'h0001, 14'h0001, 14'h0001, 14'h0005,
        14'h000A, 14'h0032, 14'h0064, 14'h00FA, 14'h01F4, 14'h03E8, 14'h09C4, 14'h1388, 14'h2710, 14'h3A98};

    // codes 1, 6 and 7 have no defined action
    function automatic stop_action_t act_of(input logic [2:0] c);
        case (c)
            3'h0: return STOP_HIZ;
            3'h2: return STOP_LOW_BRAKE;
            3'h3: return STOP_HIGH_BRAKE;
            3'h4: return STOP_SPIN_DOWN;
            3'h5: return STOP_ALIGN_BRAKE;
            default: return STOP_RESERVED;
        endcase
    endfunction

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // address phase of a write that the slave takes
    sequence s_wr(logic [31:0] a);
        hsel_i && htrans_i[1] && hwrite_i && hready_i && haddr_i == a;
    endsequence
    // data phase stores, one more cycle for the decode; data sits two cycles back
    sequence s_settled(logic [31:0] a);
        s_wr(a) ##3 1'b1;
    endsequence

    chk_stop_action:
    assert property (s_settled(A_STOP) |-> cfg_o.action == act_of($past(hwdata_i[30:28], 2)))
        else $error("stop action does not follow the written code");
    chk_brake_time:
    assert property (s_settled(A_STOP) |-> cfg_o.brake_ms == MS_TAB[$past(hwdata_i[27:24], 2)])
        else $error("brake time does not follow the written code");
    chk_motor_rl:
    assert property (s_settled(A_STOP) |-> cfg_o.res_code == $past(hwdata_i[15:8], 2)
        && cfg_o.ind_code == $past(hwdata_i[7:0], 2))
        else $error("resistance or inductance code misplaced");
    chk_bemf_code:
    assert property (s_settled(A_GAIN) |-> cfg_o.bemf_code == $past(hwdata_i[30:23], 2))
        else $error("back-emf code misplaced");
    chk_curr_gains:
    assert property (s_settled(A_GAIN) |-> cfg_o.curr_kp == $past(hwdata_i[22:13], 2)
        && cfg_o.curr_ki == $past(hwdata_i[12:3], 2))
        else $error("current loop gain code misplaced");
    chk_auto_gain:
    assert property (s_settled(A_GAIN) |-> cfg_o.curr_auto == ($past(hwdata_i[22:3], 2) == 20'h00000))
        else $error("automatic gain flag wrong");
    chk_spd_top:
    assert property (s_settled(A_GAIN) |-> cfg_o.spd_kp[9:7] == $past(hwdata_i[2:0], 2))
        else $error("speed kp top bits misplaced");
    chk_spd_low:
    assert property (s_settled(A_SPD) |-> cfg_o.spd_kp[6:0] == $past(hwdata_i[30:24], 2))
        else $error("speed kp low bits misplaced");
    chk_max_speed:
    assert property (s_settled(A_SPD) |-> cfg_o.max_speed == $past(hwdata_i[13:0], 2))
        else $error("maximum speed misplaced");
endmodule // motor_cfg_checker

bind motor_cfg_regs motor_cfg_checker #(.SPEED_W(SPEED_W), .ADDR_W(ADDR_W)) chk_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cfg_o(cfg_o), .spin_down_speed_o(spin_down_speed_o),
    .brake_speed_o(brake_speed_o)
);

// *** bench/testbench.sv ***
// self-checking bench for the motor configuration register bank
`timescale 1ns/1ps
`include "motor_cfg_consts.svh"

module testbench
    import motor_cfg_pkg::*;
;
    // ****************************************************************
    // signals and helpers
    // ****************************************************************
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0; // bus controls idle at start
    logic [31:0] haddr_i = 32'h00000000, hwdata_i = 32'h00000000, hrdata_o;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2; // word transfers only
    logic hreadyout_o, hresp_o;
    motor_cfg_t cfg_o;
    logic [13:0] spin_down_speed_o, brake_speed_o;
    int err_count = 0, compares = 0;
    logic [31:0] seed = 32'h0000001B; // fixed seed keeps runs repeatable
    // permille of maximum speed per threshold code
    localparam logic [9:0] PM [16] = '{10'h3E8, 10'h384, 10'h320, 10'h2BC, 10'h258, 10'h1F4, 10'h1C2,
        10'h190, 10'h15E, 10'h12C, 10'h0FA, 10'h0C8, 10'h096, 10'h064, 10'h032, 10'h019};

    always #25 sys_clk_i = ~sys_clk_i;

    // the one slave's ready closes the bus loop
    motor_cfg_regs #(.SPEED_W(14), .ADDR_W(32)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cfg_o(cfg_o),
        .spin_down_speed_o(spin_down_speed_o), .brake_speed_o(brake_speed_o)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // truncating division, as the speed outputs do
    function automatic logic [31:0] thr(input logic [3:0] c, input logic [13:0] m);
        return (32'(m) * 32'(PM[c])) / 32'h000003E8;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // single word transfer; waits on ready, only the watchdog ends a hang
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        @(posedge sys_clk_i);
        while (!hreadyout_o) @(posedge sys_clk_i);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        @(posedge sys_clk_i);
        while (!hreadyout_o) @(posedge sys_clk_i);
        rd = hrdata_o;
        chk({30'h0, hreadyout_o, hresp_o}, 32'h00000002);
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
    endtask

    // undefined fields come up zero, so the status shows auto gain and 1 ms
    task automatic check_reset();
        logic [31:0] rd;
        xfer(`STOP_BRAKE_RL_ADDR, 1'b0, 32'h00000000, rd);
        chk(rd, `CFG_RESET_VALUE);
        xfer(`BEMF_GAINS_ADDR, 1'b0, 32'h00000000, rd);
        chk(rd, `CFG_RESET_VALUE);
        xfer(`CFG_STATUS_ADDR, 1'b0, 32'h00000000, rd);
        chk(rd, 32'h80000001);
        chk({26'h0, cfg_o.action}, {26'h0, STOP_HIZ});
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        logic [31:0] sw, gw, pw, rd, ex;
        do_reset();
        check_reset();
        // every stop, brake and threshold code, some gain words zero or half zero
        for (int i = 0; i < 32; i++) begin
            sw = rnd();
            gw = rnd();
            pw = rnd();
            sw[30:28] = i[2:0];
            sw[27:24] = i[3:0];
            sw[23:20] = i[3:0];
            sw[19:16] = ~i[3:0];
            if (i % 4 == 0) gw[22:3] = 20'h00000;
            if (i % 4 == 2) gw[22:13] = 10'h000;
            if (i == 1) pw[13:0] = 14'h3FFF;
            xfer(`STOP_BRAKE_RL_ADDR, 1'b1, sw, rd);
            xfer(`BEMF_GAINS_ADDR, 1'b1, gw, rd);
            xfer(`SPEED_CFG_ADDR, 1'b1, pw, rd);
            xfer(`STOP_BRAKE_RL_ADDR, 1'b0, 32'h00000000, rd);
            chk(rd, sw);
            xfer(`BEMF_GAINS_ADDR, 1'b0, 32'h00000000, rd);
            chk(rd, gw);
            xfer(`SPEED_CFG_ADDR, 1'b0, 32'h00000000, rd);
            chk(rd, pw);
            ex = {gw[22:3] == 20'h00000, sw[30:28] inside {3'h1, 3'h6, 3'h7}, 30'h0};
            xfer(`CFG_STATUS_ADDR, 1'b0, 32'h00000000, rd);
            chk(rd & 32'hC0000000, ex);
            chk({18'h0, spin_down_speed_o}, thr(sw[23:20], pw[13:0]));
            chk({18'h0, brake_speed_o}, thr(sw[19:16], pw[13:0]));
        end
        // unmapped word reads zero, status ignores writes
        xfer(32'h00000244, 1'b1, rnd(), rd);
        xfer(32'h00000244, 1'b0, 32'h00000000, rd);
        chk(rd, 32'h00000000);
        xfer(`CFG_STATUS_ADDR, 1'b1, 32'h00000000, rd);
        xfer(`CFG_STATUS_ADDR, 1'b0, 32'h00000000, rd);
        chk(rd & 32'hC0000000, ex);
        do_reset();
        check_reset();
        print_verdict();
    end

    // the run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk_i);
        err_count++;
        print_verdict();
    end
endmodule // testbench
